/* File: common/term_decoder_pkg.sv */
// shared constants, register map and types for the input terminal decoder
package term_decoder_pkg;
	// terminal and data widths
	localparam int TERMS = 8;
	localparam int CODE_W = 6;
	localparam int FREQ_W = 16;
	// register byte offsets
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_MAP_LO = 8'h04;
	localparam logic [7:0] ADDR_MAP_HI = 8'h08;
	localparam logic [7:0] ADDR_UD_RATE = 8'h0C;
	localparam logic [7:0] ADDR_UD_AMPL = 8'h10;
	localparam logic [7:0] ADDR_SRC1 = 8'h14;
	localparam logic [7:0] ADDR_SRC2 = 8'h18;
	localparam logic [7:0] ADDR_BRAKE = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_FREQ_REF = 8'h24;
	localparam logic [2:0] ADDR_STEP_PAGE = 3'h2;
	// reset values
	localparam logic [31:0] CONFIG_RST = 32'h0000_0100;
	localparam logic [31:0] MAP_LO_RST = 32'h1A25_0201;
	localparam logic [31:0] MAP_HI_RST = 32'h0000_1C1B;
	localparam logic [15:0] UD_RATE_RST = 16'h0001;
	localparam logic [15:0] UD_AMPL_RST = 16'h03E8;
	localparam logic [15:0] BRAKE_RST = 16'h0000;
	// terminal function codes
	localparam logic [5:0] FN_FREQ_SEL = 6'h07;
	localparam logic [5:0] FN_JOG_FWD = 6'h08;
	localparam logic [5:0] FN_JOG_REV = 6'h09;
	localparam logic [5:0] FN_UP = 6'h0A;
	localparam logic [5:0] FN_DOWN = 6'h0B;
	localparam logic [5:0] FN_COAST = 6'h0D;
	localparam logic [5:0] FN_FSTOP = 6'h0E;
	localparam logic [5:0] FN_DC_BRAKE = 6'h0F;
	localparam logic [5:0] FN_HOLD = 6'h10;
	localparam logic [5:0] FN_PROHIBIT = 6'h11;
	localparam logic [5:0] FN_STEP1 = 6'h12;
	localparam logic [5:0] FN_CMD_TERM2 = 6'h19;
	localparam logic [5:0] FN_STEP_B0 = 6'h1A;
	localparam logic [5:0] FN_CMD_KEYPAD = 6'h1D;
	localparam logic [5:0] FN_RAMP1 = 6'h1E;
	localparam logic [5:0] FN_RAMP_B0 = 6'h22;
	localparam logic [5:0] FN_FSTOP_NC = 6'h24;
	localparam logic [5:0] FN_FAULT_NO = 6'h25;
	localparam logic [5:0] FN_FAULT_NC = 6'h26;
	localparam logic [5:0] FN_INT_NO = 6'h27;
	localparam logic [5:0] FN_INT_NC = 6'h28;
	// setting encodings
	localparam logic [3:0] SRC1_UPDOWN = 4'h7;
	localparam logic [1:0] COMB_SWITCH = 2'h1;
	localparam logic [1:0] COMB_SUM = 2'h2;
	localparam logic [1:0] SAVE_CLEAR = 2'h0;
	localparam logic [1:0] CMD_KEYPAD = 2'h0;
	localparam logic [1:0] CMD_TERM2 = 2'h2;
	localparam logic [1:0] RAMP_TIME4 = 2'h3;
	// timing: up/down and brake timebase of 1 ms
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_NS = 1000000;
	localparam int UD_TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	// drive sequencing states, gray along stop-run-brake
	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_RUN = 2'b01,
		ST_BRAKE = 2'b11,
		ST_LOCK = 2'b10
	} drive_state_t;
	// configuration word
	typedef struct packed {
		logic [1:0] cmd_src;
		logic [1:0] save_sel;
		logic [3:0] src1;
		logic [1:0] comb;
		logic polarity;
	} cfg_t;
endpackage : term_decoder_pkg

/* File: logic/step_store.sv */
// preset step frequency store with registered read data
`timescale 1ns/1ps
`default_nettype none
module step_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock
	input wire logic clk_in,
	input wire logic ce_in,
	// write port
	input wire logic wr_in,
	input wire logic [$clog2(DEPTH)-1:0] waddr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] raddr_in,
	output logic [WIDTH-1:0] rdata_out
);
	logic [WIDTH-1:0] mem [DEPTH];

	// contents are software data, so no reset is needed
	always_ff @(posedge clk_in)
	begin
		if (ce_in && wr_in)
		begin
			mem[waddr_in] <= wdata_in;
		end
	end

	// read data registered to keep the lookup off the output path
	always_ff @(posedge clk_in)
	begin
		if (ce_in)
		begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule : step_store
`default_nettype wire

/* File: logic/input_terminal_command_decoder.sv */
// multi-function input terminal decoder with register port
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module input_terminal_command_decoder #(
	parameter int UD_TICK_CYC = term_decoder_pkg::UD_TICK_CYC,
	parameter logic [7:0] FAULT_CODE = 8'h5A // arbitrary code shown for external fault
) (
	// clock, reset, enable
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	// terminal pins, high means contact closed to common
	input wire logic [term_decoder_pkg::TERMS-1:0] TERM_IN,
	// run control from drive logic on this clock
	input wire logic RUN_REQ_IN,
	input wire logic STOP_REQ_IN,
	input wire logic FAULT_RESET_IN,
	input wire logic [term_decoder_pkg::FREQ_W-1:0] CUR_FREQ_IN,
	// register port
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [31:0] RDATA_OUT,
	// drive control outputs
	output logic RUN_OUT,
	output logic MOD_EN_OUT,
	output logic JOG_FWD_OUT,
	output logic JOG_REV_OUT,
	output logic DECEL4_STOP_OUT,
	output logic DC_BRAKE_OUT,
	output logic RAMP_HOLD_OUT,
	output logic ZERO_SPEED_OUT,
	output logic FAULT_OUT,
	output logic [1:0] RAMP_SEL_OUT,
	output logic [1:0] CMD_SRC_OUT,
	output logic [term_decoder_pkg::FREQ_W-1:0] FREQ_REF_OUT
);
	localparam int TW = $clog2(UD_TICK_CYC + 1);
	localparam int FW = term_decoder_pkg::FREQ_W;

	// lowest set bit as 1-based index, zero when none
	function automatic logic [2:0] lowest_on(input logic [6:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int k = 6; k >= 0; k--)
		begin
			if (v[k])
			begin
				r = 3'(k + 1);
			end
		end
		return r;
	endfunction : lowest_on

	// clamp a signed sum into the unsigned frequency range
	function automatic logic [FW-1:0] sat_freq(input logic signed [FW+1:0] v);
		logic [FW-1:0] r;
		r = v[FW-1:0];
		if (v < 0)
		begin
			r = '0;
		end
		else if (v[FW])
		begin
			r = '1;
		end
		return r;
	endfunction : sat_freq

	term_decoder_pkg::cfg_t cfg;
	term_decoder_pkg::drive_state_t state;
	term_decoder_pkg::drive_state_t next_state;
	logic [31:0] map_lo;
	logic [31:0] map_hi;
	logic [15:0] ud_rate;
	logic [15:0] ud_ampl;
	logic [FW-1:0] src1;
	logic [FW-1:0] src2;
	logic [15:0] brake_time;
	logic [term_decoder_pkg::TERMS-1:0] sync1;
	logic [term_decoder_pkg::TERMS-1:0] sync2;
	logic [63:0] fn_on;
	logic [63:0] fn_set;
	logic [TW-1:0] tick_cnt;
	logic tick;
	logic [15:0] brake_cnt;
	logic fault;
	logic signed [FW+1:0] ud;
	logic signed [FW+1:0] ud_init;
	logic ud_busy;
	logic [2:0] step_sel;
	logic [FW-1:0] step_freq;
	logic [FW-1:0] next_ref;
	logic lock_cond;
	logic updown;
	logic ud_enable;
	logic fault_in;
	logic int_in;
	logic fstop;
	logic signed [FW+1:0] ampl_s;
	logic signed [FW+1:0] rate_s;
	logic signed [FW+1:0] src2_s;

	// config, map and settings writes
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			cfg <= term_decoder_pkg::cfg_t'(term_decoder_pkg::CONFIG_RST[10:0]);
			map_lo <= term_decoder_pkg::MAP_LO_RST;
			map_hi <= term_decoder_pkg::MAP_HI_RST;
			ud_rate <= term_decoder_pkg::UD_RATE_RST;
			ud_ampl <= term_decoder_pkg::UD_AMPL_RST;
			src1 <= '0;
			src2 <= '0;
			brake_time <= term_decoder_pkg::BRAKE_RST;
		end
		else if (CE_IN && WR_IN)
		begin
			case (ADDR_IN)
				term_decoder_pkg::ADDR_CONFIG: cfg <= term_decoder_pkg::cfg_t'(WDATA_IN[10:0]);
				term_decoder_pkg::ADDR_MAP_LO: map_lo <= WDATA_IN;
				term_decoder_pkg::ADDR_MAP_HI: map_hi <= WDATA_IN;
				term_decoder_pkg::ADDR_UD_RATE: ud_rate <= WDATA_IN[15:0];
				term_decoder_pkg::ADDR_UD_AMPL: ud_ampl <= WDATA_IN[15:0];
				term_decoder_pkg::ADDR_SRC1: src1 <= WDATA_IN[FW-1:0];
				term_decoder_pkg::ADDR_SRC2: src2 <= WDATA_IN[FW-1:0];
				term_decoder_pkg::ADDR_BRAKE: brake_time <= WDATA_IN[15:0];
				default: ;
			endcase
		end
	end

	// register readback; unmapped and preset offsets read zero
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			RDATA_OUT <= '0;
		end
		else if (CE_IN && RD_IN)
		begin
			case (ADDR_IN)
				term_decoder_pkg::ADDR_CONFIG: RDATA_OUT <= {21'h0, cfg};
				term_decoder_pkg::ADDR_MAP_LO: RDATA_OUT <= map_lo;
				term_decoder_pkg::ADDR_MAP_HI: RDATA_OUT <= map_hi;
				term_decoder_pkg::ADDR_UD_RATE: RDATA_OUT <= {16'h0, ud_rate};
				term_decoder_pkg::ADDR_UD_AMPL: RDATA_OUT <= {16'h0, ud_ampl};
				term_decoder_pkg::ADDR_SRC1: RDATA_OUT <= {16'h0, src1};
				term_decoder_pkg::ADDR_SRC2: RDATA_OUT <= {16'h0, src2};
				term_decoder_pkg::ADDR_BRAKE: RDATA_OUT <= {16'h0, brake_time};
				term_decoder_pkg::ADDR_STATUS: RDATA_OUT <= {8'h0, fault ? FAULT_CODE : 8'h0,
					3'h0, step_sel, CMD_SRC_OUT, RAMP_SEL_OUT, ZERO_SPEED_OUT, RAMP_HOLD_OUT,
					DC_BRAKE_OUT, fault, state};
				term_decoder_pkg::ADDR_FREQ_REF: RDATA_OUT <= {16'h0, FREQ_REF_OUT};
				default: RDATA_OUT <= '0;
			endcase
		end
		else if (CE_IN)
		begin
			RDATA_OUT <= '0;
		end
	end

	// two-stage sync
	// pins are asynchronous to the controller clock
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else if (CE_IN)
		begin
			sync1 <= TERM_IN;
			sync2 <= sync1;
		end
	end

	// map each terminal's level onto its function; repeated functions are or-ed
	always_comb
	begin
		logic [term_decoder_pkg::CODE_W-1:0] c;
		logic lvl;
		fn_on = '0;
		fn_set = '0;
		c = '0;
		lvl = 1'b0;
		for (int i = 0; i < term_decoder_pkg::TERMS; i++)
		begin
			c = (i < 4) ? map_lo[8*i +: 6] : map_hi[8*(i-4) +: 6];
			lvl = cfg.polarity ? ~sync2[i] : sync2[i];
			case (c)
				term_decoder_pkg::FN_FAULT_NO: lvl = sync2[i];
				term_decoder_pkg::FN_INT_NO: lvl = sync2[i];
				term_decoder_pkg::FN_FAULT_NC: lvl = ~sync2[i];
				term_decoder_pkg::FN_INT_NC: lvl = ~sync2[i];
				term_decoder_pkg::FN_FSTOP_NC: lvl = ~lvl;
				default: ;
			endcase
			if (c != '0)
			begin
				fn_set[c] = 1'b1;
				fn_on[c] = fn_on[c] | lvl;
			end
		end
	end
	assign fault_in = fn_on[term_decoder_pkg::FN_FAULT_NO] | fn_on[term_decoder_pkg::FN_FAULT_NC];
	assign int_in = fn_on[term_decoder_pkg::FN_INT_NO] | fn_on[term_decoder_pkg::FN_INT_NC];
	assign fstop = fn_on[term_decoder_pkg::FN_FSTOP] | fn_on[term_decoder_pkg::FN_FSTOP_NC];
	// prohibit joins coast lockout
	// the raw fault input locks at once, so a run cannot start in the latch's set cycle
	assign lock_cond = fn_on[term_decoder_pkg::FN_COAST] | fn_on[term_decoder_pkg::FN_PROHIBIT]
		| fault | fault_in;
	assign updown = fn_on[term_decoder_pkg::FN_UP] | fn_on[term_decoder_pkg::FN_DOWN];
	assign ud_enable = (state == term_decoder_pkg::ST_RUN) && (cfg.src1 == term_decoder_pkg::SRC1_UPDOWN);
	assign ampl_s = $signed({2'b00, ud_ampl});
	assign rate_s = $signed({2'b00, ud_rate});
	assign src2_s = $signed({2'b00, src2});

	// millisecond timebase shared by up/down ramp and brake timer
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			tick_cnt <= '0;
		end
		else if (CE_IN)
		begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
		end
	end
	assign tick = (tick_cnt == TW'(UD_TICK_CYC - 1));

	// fault latch
	// set wins over reset; reset is refused while the input stays active
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			fault <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (fault_in)
			begin
				fault <= 1'b1;
			end
			else if (FAULT_RESET_IN)
			begin
				fault <= 1'b0;
			end
		end
	end

	// brake hold timer
	// the timer starts when braking begins, so the longer of both wins
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			brake_cnt <= '0;
		end
		else if (CE_IN)
		begin
			if (state != term_decoder_pkg::ST_BRAKE && next_state == term_decoder_pkg::ST_BRAKE)
			begin
				brake_cnt <= brake_time;
			end
			else if (tick && brake_cnt != '0)
			begin
				brake_cnt <= brake_cnt - 1'b1;
			end
		end
	end

	// drive sequencing
	always_comb
	begin
		next_state = state;
		case (state)
			term_decoder_pkg::ST_STOP:
			begin
				// braking may be asked for at standstill too
				if (!lock_cond && fn_on[term_decoder_pkg::FN_DC_BRAKE])
				begin
					next_state = term_decoder_pkg::ST_BRAKE;
				end
				else if (!lock_cond && RUN_REQ_IN && !fstop && !STOP_REQ_IN)
				begin
					next_state = term_decoder_pkg::ST_RUN;
				end
			end
			term_decoder_pkg::ST_RUN:
			begin
				if (lock_cond)
				begin
					next_state = term_decoder_pkg::ST_LOCK;
				end
				else if (fn_on[term_decoder_pkg::FN_DC_BRAKE])
				begin
					next_state = term_decoder_pkg::ST_BRAKE;
				end
				else if (STOP_REQ_IN || !RUN_REQ_IN || fstop)
				begin
					next_state = term_decoder_pkg::ST_STOP;
				end
			end
			term_decoder_pkg::ST_BRAKE:
			begin
				if (lock_cond)
				begin
					next_state = term_decoder_pkg::ST_LOCK;
				end
				else if (!fn_on[term_decoder_pkg::FN_DC_BRAKE] && brake_cnt == '0)
				begin
					next_state = term_decoder_pkg::ST_STOP;
				end
			end
			term_decoder_pkg::ST_LOCK:
			begin
				if (!lock_cond)
				begin
					next_state = term_decoder_pkg::ST_STOP;
				end
			end
			default: next_state = term_decoder_pkg::ST_STOP;
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			state <= term_decoder_pkg::ST_STOP;
		end
		else if (CE_IN)
		begin
			state <= next_state;
		end
	end

	// up/down value: ramps, clamps, captures and saves at stop
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			ud <= '0;
			ud_init <= '0;
			ud_busy <= 1'b0;
		end
		else if (CE_IN)
		begin
			ud_busy <= ud_enable && updown;
			if (state == term_decoder_pkg::ST_RUN && next_state != term_decoder_pkg::ST_RUN)
			begin
				if (updown)
				begin
					ud <= ud_init;
				end
				else if (cfg.save_sel == term_decoder_pkg::SAVE_CLEAR)
				begin
					ud <= '0;
				end
			end
			else if (ud_enable && updown)
			begin
				if (!ud_busy)
				begin
					ud_init <= ud;
				end
				if (!ud_busy && cfg.comb != term_decoder_pkg::COMB_SUM)
				begin
					ud <= $signed({2'b00, CUR_FREQ_IN});
				end
				else if (tick)
				begin
					if (fn_on[term_decoder_pkg::FN_UP])
					begin
						ud <= (cfg.comb == term_decoder_pkg::COMB_SUM && ud + rate_s > ampl_s)
							? ampl_s : ud + rate_s;
					end
					else if (cfg.comb == term_decoder_pkg::COMB_SUM)
					begin
						ud <= (ud - rate_s < -ampl_s) ? -ampl_s : ud - rate_s;
					end
					else
					begin
						ud <= (ud < rate_s) ? '0 : ud - rate_s;
					end
				end
			end
			else if (ud_busy && cfg.comb != term_decoder_pkg::COMB_SUM)
			begin
				ud <= $signed({2'b00, CUR_FREQ_IN});
			end
		end
	end

	// step selection: individual, binary, all assigned, priority
	always_comb
	begin
		step_sel = lowest_on(fn_on[term_decoder_pkg::FN_STEP1 +: 7]);
		if (step_sel == 3'h0 && (&fn_set[term_decoder_pkg::FN_STEP_B0 +: 3]))
		begin
			step_sel = {fn_on[term_decoder_pkg::FN_STEP_B0 + 2],
				fn_on[term_decoder_pkg::FN_STEP_B0 + 1], fn_on[term_decoder_pkg::FN_STEP_B0]};
		end
	end

	step_store #(
		.WIDTH(FW),
		.DEPTH(8)
	) u_step_store (
		.clk_in(CLK_IN),
		.ce_in(CE_IN),
		.wr_in(WR_IN && ADDR_IN[7:5] == term_decoder_pkg::ADDR_STEP_PAGE && ADDR_IN[1:0] == 2'h0),
		.waddr_in(ADDR_IN[4:2]),
		.wdata_in(WDATA_IN[FW-1:0]),
		.raddr_in(step_sel),
		.rdata_out(step_freq)
	);

	// reference selection
	always_comb
	begin
		next_ref = src1;
		if (cfg.src1 == term_decoder_pkg::SRC1_UPDOWN)
		begin
			next_ref = sat_freq(ud);
		end
		if (cfg.comb == term_decoder_pkg::COMB_SWITCH && fn_on[term_decoder_pkg::FN_FREQ_SEL])
		begin
			next_ref = src2;
		end
		else if (cfg.comb == term_decoder_pkg::COMB_SUM)
		begin
			next_ref = sat_freq(ud + src2_s);
		end
		if (step_sel != 3'h0)
		begin
			next_ref = step_freq;
		end
		if (int_in)
		begin
			next_ref = '0;
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			FREQ_REF_OUT <= '0;
		end
		else if (CE_IN && (!fn_on[term_decoder_pkg::FN_HOLD] || int_in))
		begin
			FREQ_REF_OUT <= next_ref;
		end
	end

	// drive control outputs, registered
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			RUN_OUT <= 1'b0;
			MOD_EN_OUT <= 1'b0;
			JOG_FWD_OUT <= 1'b0;
			JOG_REV_OUT <= 1'b0;
			DECEL4_STOP_OUT <= 1'b0;
			DC_BRAKE_OUT <= 1'b0;
			RAMP_HOLD_OUT <= 1'b0;
			ZERO_SPEED_OUT <= 1'b0;
		end
		else if (CE_IN)
		begin
			RUN_OUT <= next_state == term_decoder_pkg::ST_RUN;
			MOD_EN_OUT <= !lock_cond && (next_state != term_decoder_pkg::ST_STOP
				|| JOG_FWD_OUT || JOG_REV_OUT);
			JOG_FWD_OUT <= fn_on[term_decoder_pkg::FN_JOG_FWD] && !RUN_REQ_IN && !lock_cond
				&& next_state == term_decoder_pkg::ST_STOP;
			JOG_REV_OUT <= fn_on[term_decoder_pkg::FN_JOG_REV] && !fn_on[term_decoder_pkg::FN_JOG_FWD]
				&& !RUN_REQ_IN && !lock_cond && next_state == term_decoder_pkg::ST_STOP;
			DECEL4_STOP_OUT <= fstop;
			DC_BRAKE_OUT <= next_state == term_decoder_pkg::ST_BRAKE;
			RAMP_HOLD_OUT <= fn_on[term_decoder_pkg::FN_HOLD] && !STOP_REQ_IN;
			ZERO_SPEED_OUT <= int_in && next_state == term_decoder_pkg::ST_RUN;
		end
	end

	// ramp time and command source
	always_ff @(posedge CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			RAMP_SEL_OUT <= '0;
			CMD_SRC_OUT <= term_decoder_pkg::CMD_KEYPAD;
		end
		else if (CE_IN)
		begin
			if (fstop)
			begin
				RAMP_SEL_OUT <= term_decoder_pkg::RAMP_TIME4;
			end
			else if (lowest_on({3'h0, fn_on[term_decoder_pkg::FN_RAMP1 +: 4]}) != 3'h0)
			begin
				RAMP_SEL_OUT <= 2'(lowest_on({3'h0, fn_on[term_decoder_pkg::FN_RAMP1 +: 4]}) - 3'h1);
			end
			else
			begin
				RAMP_SEL_OUT <= {fn_on[term_decoder_pkg::FN_RAMP_B0 + 1], fn_on[term_decoder_pkg::FN_RAMP_B0]};
			end
			if (fn_on[term_decoder_pkg::FN_CMD_KEYPAD])
			begin
				CMD_SRC_OUT <= term_decoder_pkg::CMD_KEYPAD;
			end
			else if (fn_on[term_decoder_pkg::FN_CMD_TERM2])
			begin
				CMD_SRC_OUT <= term_decoder_pkg::CMD_TERM2;
			end
			else
			begin
				CMD_SRC_OUT <= cfg.cmd_src;
			end
		end
	end

	assign FAULT_OUT = fault;
endmodule : input_terminal_command_decoder
`default_nettype wire

/* File: verification/decoder_monitor.sv */
// port checker for the terminal decoder
`timescale 1ns/1ps
`default_nettype none
module decoder_monitor (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// drive outputs
	input wire logic RUN_OUT,
	input wire logic MOD_EN_OUT,
	input wire logic JOG_FWD_OUT,
	input wire logic JOG_REV_OUT,
	input wire logic DECEL4_STOP_OUT,
	input wire logic RAMP_HOLD_OUT,
	input wire logic ZERO_SPEED_OUT,
	input wire logic FAULT_OUT,
	input wire logic [1:0] RAMP_SEL_OUT,
	input wire logic [term_decoder_pkg::FREQ_W-1:0] FREQ_REF_OUT
);
	default clocking dc @(posedge CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	a_fault_stops: assert property (FAULT_OUT && $past(FAULT_OUT) |-> !RUN_OUT && !MOD_EN_OUT)
		else $error("output alive under fault");
	a_run_needs_clear: assert property ($rose(RUN_OUT) |-> !FAULT_OUT)
		else $error("run started with fault latched");
	a_jog_single: assert property (!(JOG_FWD_OUT && JOG_REV_OUT))
		else $error("both jog requests up");
	a_jog_from_stop: assert property ($rose(JOG_FWD_OUT) || $rose(JOG_REV_OUT) |-> !$past(RUN_OUT))
		else $error("jog started while running");
	a_decel_ramp: assert property (DECEL4_STOP_OUT && $past(DECEL4_STOP_OUT) |-> RAMP_SEL_OUT == 2'h3)
		else $error("forced stop not on ramp time 4");
	a_decel_stops: assert property (DECEL4_STOP_OUT && $past(DECEL4_STOP_OUT) |-> !RUN_OUT)
		else $error("forced stop left drive running");
	a_zero_ref: assert property (ZERO_SPEED_OUT && $past(ZERO_SPEED_OUT) |-> FREQ_REF_OUT == 16'h0000)
		else $error("interrupt did not zero reference");
	a_hold_freeze: assert property (RAMP_HOLD_OUT && $past(RAMP_HOLD_OUT) && RUN_OUT && $past(RUN_OUT)
		&& !ZERO_SPEED_OUT && !$past(ZERO_SPEED_OUT) |-> $stable(FREQ_REF_OUT))
		else $error("reference moved under hold");
	// main scenarios seen
	c_jog: cover property ($rose(JOG_FWD_OUT));
	c_fault: cover property ($rose(FAULT_OUT));
	c_hold_run: cover property (RAMP_HOLD_OUT && RUN_OUT);
endmodule : decoder_monitor
bind input_terminal_command_decoder decoder_monitor u_decoder_monitor (
	.CLK_IN, .RESETN_IN, .RUN_OUT, .MOD_EN_OUT, .JOG_FWD_OUT, .JOG_REV_OUT,
	.DECEL4_STOP_OUT, .RAMP_HOLD_OUT, .ZERO_SPEED_OUT, .FAULT_OUT, .RAMP_SEL_OUT, .FREQ_REF_OUT
);
`default_nettype wire

/* File: verification/contact_model.sv */
// switch contacts feeding the terminal pins
`timescale 1ns/1ps
`default_nettype none
module contact_model (
	// wanted contact states, 1 = closed
	input wire logic [term_decoder_pkg::TERMS-1:0] closed_in,
	// terminal pins, high = closed to common
	output logic [term_decoder_pkg::TERMS-1:0] term_out
);
	// lag keeps pin edges off the clock; bounce is left out, the synchroniser does not filter it
	assign #3 term_out = closed_in;
endmodule : contact_model
`default_nettype wire

/* File: verification/input_terminal_command_decoder_tb.sv */
// self-checking bench for the terminal decoder
`timescale 1ns/1ps
`default_nettype none
module input_terminal_command_decoder_tb;
	logic clk, resetn, run_req, stop_req, fault_rst, wr, rd;
	logic [7:0] addr, closed, term;
	logic [31:0] wdata, rdata;
	logic run, mod_en, jog_f, jog_r, decel4, brake, hold, zero, fault;
	logic [1:0] ramp_sel, cmd_src;
	logic [15:0] freq_ref, cur_freq;
	int n_errors = 0;
	int num_checks = 0;
	// contacts and block under test, short tick for brake timing
	contact_model u_contact_model (.closed_in(closed), .term_out(term));
	input_terminal_command_decoder #(.UD_TICK_CYC(8)) u_input_terminal_command_decoder (
		.CLK_IN(clk), .RESETN_IN(resetn), .CE_IN(1'b1), .TERM_IN(term),
		.RUN_REQ_IN(run_req), .STOP_REQ_IN(stop_req), .FAULT_RESET_IN(fault_rst),
		.CUR_FREQ_IN(cur_freq), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
		.RDATA_OUT(rdata), .RUN_OUT(run), .MOD_EN_OUT(mod_en), .JOG_FWD_OUT(jog_f),
		.JOG_REV_OUT(jog_r), .DECEL4_STOP_OUT(decel4), .DC_BRAKE_OUT(brake),
		.RAMP_HOLD_OUT(hold), .ZERO_SPEED_OUT(zero), .FAULT_OUT(fault),
		.RAMP_SEL_OUT(ramp_sel), .CMD_SRC_OUT(cmd_src), .FREQ_REF_OUT(freq_ref));
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic print_verdict;
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : tick
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rd_reg
	// map X1 and X2, move contacts, wait out sync and output flops
	task automatic apply(input logic [5:0] c1, input logic [5:0] c2, input logic [7:0] k);
		wr_reg(8'h04, {18'h00000, c2, 2'h0, c1});
		closed <= k;
		tick(5);
	endtask : apply
	task automatic go(input logic r);
		@(posedge clk);
		run_req <= r;
		tick(3);
	endtask : go
	task automatic pulse_rst;
		@(posedge clk);
		fault_rst <= 1'b1;
		@(posedge clk);
		fault_rst <= 1'b0;
		tick(3);
	endtask : pulse_rst
	task automatic t_regs;
		rd_reg(8'h00, 32'h0000_0100);
		rd_reg(8'h08, 32'h0000_1C1B);
		wr_reg(8'h3C, 32'hFFFF_FFFF);
		rd_reg(8'h3C, 32'h0000_0000);
		rd_reg(8'h44, 32'h0000_0000);
		wr_reg(8'h08, 32'h0000_0000);
	endtask : t_regs
	task automatic t_src;
		wr_reg(8'h14, 32'h0000_0457);
		wr_reg(8'h18, 32'h0000_08AE);
		wr_reg(8'h00, 32'h0000_0302);
		apply(6'h07, 6'h19, 8'h01);
		chk(freq_ref, 16'h08AE);
		apply(6'h07, 6'h19, 8'h02);
		chk({freq_ref, cmd_src}, 18'h0115E);
		apply(6'h1D, 6'h19, 8'h03);
		chk(cmd_src, 2'h0);
		apply(6'h00, 6'h00, 8'hFF);
		chk({cmd_src, hold, decel4}, 4'h4);
		wr_reg(8'h00, 32'h0000_0304);
		tick(3);
		chk(freq_ref, 16'h08AE);
		wr_reg(8'h00, 32'h0000_0300);
	endtask : t_src
	task automatic t_ramp;
		apply(6'h21, 6'h1F, 8'h03);
		chk(ramp_sel, 2'h1);
		for (int i = 0; i < 4; i++)
		begin
			apply(6'h22, 6'h23, i[7:0]);
			chk(ramp_sel, i[1:0]);
		end
		apply(6'h20, 6'h23, 8'h03);
		chk(ramp_sel, 2'h2);
	endtask : t_ramp
	// step speeds, presets are 100 times the step
	task automatic t_step;
		for (int i = 1; i < 8; i++)
			wr_reg(8'(64 + 4 * i), 32'(100 * i));
		wr_reg(8'h08, 32'h1A17_1B1C);
		apply(6'h1A, 6'h14, 8'h11);
		chk(freq_ref, 16'h01F4);
		apply(6'h1A, 6'h14, 8'h90);
		chk(freq_ref, 16'h01F4);
		apply(6'h1A, 6'h14, 8'h51);
		chk(freq_ref, 16'h0258);
		apply(6'h1A, 6'h14, 8'h42);
		chk(freq_ref, 16'h012C);
		wr_reg(8'h08, 32'h0000_0000);
	endtask : t_step
	task automatic t_stop;
		apply(6'h0D, 6'h11, 8'h00);
		go(1'b1);
		chk(run, 1'b1);
		apply(6'h0D, 6'h11, 8'h01);
		chk({run, mod_en}, 2'h0);
		apply(6'h0D, 6'h11, 8'h00);
		chk(run, 1'b1);
		go(1'b0);
		go(1'b1);
		apply(6'h0D, 6'h11, 8'h02);
		go(1'b0);
		go(1'b1);
		chk(run, 1'b0);
		apply(6'h10, 6'h27, 8'h00);
		go(1'b0);
		go(1'b1);
		apply(6'h10, 6'h27, 8'h02);
		chk({zero, freq_ref}, 17'h10000);
		apply(6'h10, 6'h27, 8'h00);
		chk({zero, freq_ref}, 17'h00457);
		apply(6'h10, 6'h27, 8'h01);
		chk({run, hold}, 2'h3);
		@(posedge clk);
		stop_req <= 1'b1;
		@(posedge clk);
		stop_req <= 1'b0;
		@(negedge clk);
		chk(run, 1'b0);
		go(1'b0);
		chk(run, 1'b0);
		apply(6'h08, 6'h09, 8'h02);
		chk({jog_f, jog_r}, 2'h1);
		apply(6'h08, 6'h09, 8'h03);
		chk({jog_f, jog_r}, 2'h2);
		apply(6'h08, 6'h09, 8'h00);
		go(1'b1);
		apply(6'h08, 6'h09, 8'h01);
		chk(jog_f, 1'b0);
	endtask : t_stop
	task automatic t_fault;
		apply(6'h0E, 6'h24, 8'h03);
		chk({decel4, ramp_sel, run}, 4'hE);
		apply(6'h0E, 6'h24, 8'h02);
		chk(decel4, 1'b0);
		apply(6'h0E, 6'h24, 8'h00);
		chk(decel4, 1'b1);
		go(1'b0);
		wr_reg(8'h1C, 32'h0000_0006);
		apply(6'h25, 6'h0F, 8'h01);
		chk({fault, run}, 2'h2);
		pulse_rst;
		chk(fault, 1'b1);
		apply(6'h25, 6'h0F, 8'h02);
		pulse_rst;
		chk({fault, brake}, 2'h1);
		apply(6'h25, 6'h0F, 8'h00);
		chk(brake, 1'b1);
		tick(70);
		chk(brake, 1'b0);
		wr_reg(8'h00, 32'h0000_0301);
		apply(6'h10, 6'h25, 8'h00);
		chk({hold, fault}, 2'h2);
	endtask : t_fault
	// up/down, sum mode with amplitude 3, then plain mode from running frequency
	task automatic t_updown;
		wr_reg(8'h10, 32'h0000_0003);
		wr_reg(8'h00, 32'h0000_003C);
		apply(6'h0A, 6'h0B, 8'h00);
		go(1'b1);
		tick(60);
		chk({run, freq_ref}, 17'h108AE);
		apply(6'h0A, 6'h0B, 8'h01);
		tick(40);
		chk(freq_ref, 16'h08B1);
		apply(6'h0A, 6'h0B, 8'h02);
		tick(60);
		chk(freq_ref, 16'h08AB);
		apply(6'h0A, 6'h0B, 8'h00);
		tick(20);
		chk(freq_ref, 16'h08AB);
		go(1'b0);
		chk(freq_ref, 16'h08AE);
		apply(6'h0A, 6'h0B, 8'h01);
		chk(freq_ref, 16'h08AE);
		wr_reg(8'h00, 32'h0000_0038);
		go(1'b1);
		tick(20);
		apply(6'h0A, 6'h0B, 8'h00);
		chk(freq_ref, 16'h0123);
	endtask : t_updown
	// watchdog well beyond the planned run
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict;
	end
	// reset, then the scenarios
	initial
	begin
		{resetn, run_req, stop_req, fault_rst, wr, rd} = 6'h00;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		closed = 8'h00;
		cur_freq = 16'h0123;
		tick(11);
		@(posedge clk);
		resetn <= 1'b1;
		t_regs;
		t_src;
		t_ramp;
		t_step;
		t_stop;
		t_fault;
		t_updown;
		print_verdict;
	end
endmodule : input_terminal_command_decoder_tb
`default_nettype wire
